// >>> inc/pst_cfg.svh
// Constants for the status and telemetry register set.
`ifndef PST_CFG_SVH
`define PST_CFG_SVH
`define PST_NCH 8
`define PST_CMD_STAT_TEMP 8'h7D
`define PST_CMD_STAT_CML 8'h7E
`define PST_CMD_STAT_MFR 8'h80
`define PST_CMD_READ_VIN 8'h88
`define PST_CMD_READ_VOUT 8'h8B
`define PST_CMD_READ_TEMP 8'h8D
`define PST_CML_CMD 7
`define PST_CML_DATA 6
`define PST_CML_PEC 5
`define PST_CML_MEM 4
`define PST_CML_BUS 1
`define PST_EV_CLR 0
`define PST_EV_CMD 1
`define PST_EV_DATA 2
`define PST_EV_PEC 3
`define PST_EV_BUS 4
`define PST_NEV 5
`define PST_EXP_VOUT 5'h13
`define PST_EXP_HIRES 5'h1A
`define PST_EXP_VIN 5'h18
`define PST_EXP_TEMP 5'h1E
`define PST_RST_FLAGS 8'h00
`define PST_RST_WORD 16'h0000
`endif

// >>> inc/pst_pkg.sv
// Types shared by the status and telemetry register set.
package pst_pkg;
    typedef struct packed {
        logic ot_fault;
        logic ot_warn;
        logic ut_warn;
        logic ut_fault;
    } pst_temp_t;
    typedef struct packed {
        logic bus_fault;
        logic data_fault;
        logic cmd_fault;
        logic clear_faults;
    } pst_lkev_t;
    typedef struct packed {
        logic [7:0] cmd;
        logic [2:0] page;
    } pst_rdreq_t;
endpackage

// >>> rtl/pst_status.sv
// Status flags and telemetry read-back of an eight-channel power manager.
`timescale 1ns/1ps
`include "pst_cfg.svh"
// What this block does
// - Temperature faults and warnings in bits 7..4.
// - Temperature status low nibble reads zero.
// - Illegal command sets communication bit 7.
// - Illegal data sets communication bit 6.
// - Packet error checking always on, bit 5.
// - Extra byte not matching PEC flags error.
// - Configuration memory fault sets bit 4.
// - Communication bits 3, 2, 0 read zero.
// - Other malformed transaction sets bit 1.
// - Sticky bits clear on fault-clear; per-channel vendor bits also clear on turn-on.
// - Alerting bit set pulls alert line low.
// - Vendor bits 7..2 per page, 1..0 global.
// - Discharge fault: sticky, alerting, may turn off.
// - Shared fault line hits tracked per channel.
// - Servo reached and DAC connected, live bits.
// - DAC saturation sticky, not alerting.
// - Supply enable dropped bit 1, live, global.
// - Watchdog timeout bit 0, sticky, alerting.
// - Input voltage read returns linear-11 volts.
// - Output voltage L16 volts, hires odd L11 mV.
// - Die temperature read returns linear-11 Celsius.
// - Odd-channel fine setting selects finer LSB.
module pst_status (
    // System clock domain
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // Host bus side, on the link clock
    input wire logic bus_clk,
    input wire pst_pkg::pst_lkev_t lk_evt,
    input wire logic lk_extra_valid,
    input wire logic [7:0] lk_extra_byte,
    input wire logic [7:0] lk_pec_expected,
    input wire logic lk_rd_req,
    input wire pst_pkg::pst_rdreq_t lk_rd_addr,
    output logic [15:0] lk_rd_data,
    output logic lk_rd_valid,
    output logic lk_rd_busy,
    // Supervisors and memory
    input wire pst_pkg::pst_temp_t temp_evt,
    input wire logic nvm_fault,
    input wire logic watchdog_timeout,
    input wire logic vinen_faulted_off,
    // Per-channel conditions
    input wire logic [7:0] discharge_fault,
    input wire logic [7:0] on_attempt,
    input wire logic [7:0] shut_by_fault0,
    input wire logic [7:0] shut_by_fault1,
    input wire logic [7:0] control_toggle,
    input wire logic [7:0] commanded_on,
    input wire logic [7:0] servo_reached,
    input wire logic [7:0] dac_driving,
    input wire logic [7:0] dac_saturated,
    input wire logic [7:0] off_on_fault_en,
    input wire logic [7:0] adc_hires,
    output logic [7:0] chan_off_req,
    // ADC samples
    input wire logic vin_valid,
    input wire logic [15:0] vin_sample,
    input wire logic temp_valid,
    input wire logic [15:0] temp_sample,
    input wire logic [7:0] vout_valid,
    input wire logic [127:0] vout_sample,
    // Shared fault pins and alert request
    input wire logic shared_fault_line0_n,
    input wire logic shared_fault_line1_n,
    output logic alert_request_line_n_o,
    output logic alert_request_line_n_oe
);
    import pst_pkg::*;

    // Linear-11 normalisation; shifting trades low bits for range.
    function automatic logic [15:0] pst_l11(input logic [15:0] raw,
                                            input logic [4:0] base);
        logic signed [15:0] m;
        logic [4:0] e;
        m = raw;
        e = base;
        for (int i = 0; i < 5; i++) begin
            if (m[15:10] != {6{m[15]}}) begin
                m = m >>> 1;
                e = e + 5'h01;
            end
        end
        return {e, m[10:0]};
    endfunction

    // Link-domain reset, brought over from the system reset.
    logic lrst_s1_q;
    logic lrst_q;
    always_ff @(posedge bus_clk) begin
        lrst_s1_q <= reset;
        lrst_q <= lrst_s1_q;
    end

    // Link events become toggles; two events closer than one
    // system cycle of the same kind may cancel and both be lost.
    logic [`PST_NEV-1:0] lk_ev;
    logic [`PST_NEV-1:0] ev_tgl_q;
    logic pec_bad;
    assign pec_bad = lk_extra_valid &&
                     (lk_extra_byte != lk_pec_expected);
    assign lk_ev = {lk_evt.bus_fault, pec_bad, lk_evt.data_fault,
                    lk_evt.cmd_fault, lk_evt.clear_faults};
    always_ff @(posedge bus_clk) begin
        if (lrst_q) begin
            ev_tgl_q <= '0;
        end else begin
            ev_tgl_q <= ev_tgl_q ^ lk_ev;
        end
    end

    // Read request handshake, link side.
    pst_rdreq_t req_q;
    logic req_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic ack_tgl_q;
    logic [15:0] rsp_q;
    always_ff @(posedge bus_clk) begin
        ack_s1_q <= ack_tgl_q;
        ack_s2_q <= ack_s1_q;
        ack_s3_q <= ack_s2_q;
    end
    always_ff @(posedge bus_clk) begin
        if (lrst_q) begin
            req_q <= '0;
            req_tgl_q <= 1'b0;
            lk_rd_busy <= 1'b0;
            lk_rd_valid <= 1'b0;
            lk_rd_data <= `PST_RST_WORD;
        end else begin
            lk_rd_valid <= 1'b0;
            if (lk_rd_busy && (ack_s2_q != ack_s3_q)) begin
                lk_rd_data <= rsp_q;
                lk_rd_valid <= 1'b1;
                lk_rd_busy <= 1'b0;
            end else if (lk_rd_req && !lk_rd_busy) begin
                req_q <= lk_rd_addr;
                req_tgl_q <= ~req_tgl_q;
                lk_rd_busy <= 1'b1;
            end
        end
    end

    // System-side synchronisers.
    logic [`PST_NEV-1:0] ev_s1_q;
    logic [`PST_NEV-1:0] ev_s2_q;
    logic [`PST_NEV-1:0] ev_s3_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic [1:0] fl_s1_q;
    logic [1:0] fl_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_s3_q <= '0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            fl_s1_q <= 2'h3;
            fl_q <= 2'h3;
        end else if (ce) begin
            ev_s1_q <= ev_tgl_q;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            fl_s1_q <= {shared_fault_line1_n, shared_fault_line0_n};
            fl_q <= fl_s1_q;
        end
    end
    logic [`PST_NEV-1:0] ev;
    logic req_edge;
    logic clr;
    assign ev = ev_s2_q ^ ev_s3_q;
    assign req_edge = req_s2_q ^ req_s3_q;
    assign clr = ev[`PST_EV_CLR];

    // Command decode of the held request.
    logic known_cmd;
    always_comb begin
        case (req_q.cmd)
            `PST_CMD_STAT_TEMP, `PST_CMD_STAT_CML, `PST_CMD_STAT_MFR,
            `PST_CMD_READ_VIN, `PST_CMD_READ_VOUT,
            `PST_CMD_READ_TEMP: known_cmd = 1'b1;
            default: known_cmd = 1'b0;
        endcase
    end

    // Temperature status, sticky until a fault clear.
    logic [3:0] temp_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            temp_q <= 4'h0;
        end else if (ce) begin
            temp_q <= (clr ? 4'h0 : temp_q) | temp_evt;
        end
    end

    // Communication, memory and logic status; set wins over clear.
    logic [7:0] cml_set;
    logic [7:0] cml_q;
    always_comb begin
        cml_set = `PST_RST_FLAGS;
        cml_set[`PST_CML_CMD] = ev[`PST_EV_CMD] ||
                                (req_edge && !known_cmd);
        cml_set[`PST_CML_DATA] = ev[`PST_EV_DATA];
        cml_set[`PST_CML_PEC] = ev[`PST_EV_PEC];
        cml_set[`PST_CML_MEM] = nvm_fault;
        cml_set[`PST_CML_BUS] = ev[`PST_EV_BUS];
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            cml_q <= `PST_RST_FLAGS;
        end else if (ce) begin
            cml_q <= (clr ? `PST_RST_FLAGS : cml_q) | cml_set;
        end
    end

    // Per-channel vendor flags.
    logic [7:0] disch_q;
    logic [7:0] f1_q;
    logic [7:0] f0_q;
    logic [7:0] sat_q;
    logic [7:0] vout_fine;
    logic [15:0] vout_q [0:7];
    genvar c;
    generate
        for (c = 0; c < `PST_NCH; c++) begin : g_ch
            logic rel;
            logic lrel;
            assign rel = clr || commanded_on[c];
            assign lrel = rel || control_toggle[c];
            assign vout_fine[c] = adc_hires[c] && (c % 2 == 1);
            always_ff @(posedge mclk) begin
                if (reset) begin
                    disch_q[c] <= 1'b0;
                    f1_q[c] <= 1'b0;
                    f0_q[c] <= 1'b0;
                    sat_q[c] <= 1'b0;
                    vout_q[c] <= `PST_RST_WORD;
                end else if (ce) begin
                    disch_q[c] <= (disch_q[c] && !rel) ||
                                  discharge_fault[c];
                    f1_q[c] <= (f1_q[c] && !lrel) || shut_by_fault1[c] ||
                               (on_attempt[c] && !fl_q[1]);
                    f0_q[c] <= (f0_q[c] && !lrel) || shut_by_fault0[c] ||
                               (on_attempt[c] && !fl_q[0]);
                    sat_q[c] <= (sat_q[c] && !rel) || dac_saturated[c];
                    if (vout_valid[c]) begin
                        vout_q[c] <= vout_sample[16*c +: 16];
                    end
                end
            end
        end
    endgenerate

    // Global vendor flag and the remaining samples.
    logic wdog_q;
    logic [15:0] vin_q;
    logic [15:0] tsmp_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            wdog_q <= 1'b0;
            vin_q <= `PST_RST_WORD;
            tsmp_q <= `PST_RST_WORD;
        end else if (ce) begin
            wdog_q <= (wdog_q && !clr) || watchdog_timeout;
            if (vin_valid) begin
                vin_q <= vin_sample;
            end
            if (temp_valid) begin
                tsmp_q <= temp_sample;
            end
        end
    end

    // Alert and channel-off requests; the watchdog never turns off.
    logic alert_now;
    assign alert_now = |{disch_q, f1_q, f0_q, wdog_q};
    always_ff @(posedge mclk) begin
        if (reset) begin
            alert_request_line_n_o <= 1'b0;
            alert_request_line_n_oe <= 1'b0;
            chan_off_req <= 8'h00;
        end else if (ce) begin
            alert_request_line_n_o <= 1'b0;
            alert_request_line_n_oe <= alert_now;
            chan_off_req <= (disch_q | f1_q | f0_q) & off_on_fault_en;
        end
    end

    // Read data for the held request; reading never clears a flag.
    logic [15:0] rd_mux;
    logic [2:0] pg;
    assign pg = req_q.page;
    always_comb begin
        case (req_q.cmd)
            `PST_CMD_STAT_TEMP: rd_mux = {8'h00, temp_q, 4'h0};
            `PST_CMD_STAT_CML: rd_mux = {8'h00, cml_q};
            `PST_CMD_STAT_MFR: rd_mux = {8'h00, disch_q[pg], f1_q[pg],
                f0_q[pg], servo_reached[pg], dac_driving[pg],
                sat_q[pg], vinen_faulted_off, wdog_q};
            `PST_CMD_READ_VIN: rd_mux = pst_l11(vin_q, `PST_EXP_VIN);
            `PST_CMD_READ_VOUT: rd_mux = vout_fine[pg] ?
                pst_l11(vout_q[pg], `PST_EXP_HIRES) : vout_q[pg];
            `PST_CMD_READ_TEMP: rd_mux = pst_l11(tsmp_q, `PST_EXP_TEMP);
            default: rd_mux = `PST_RST_WORD;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_q <= `PST_RST_WORD;
            ack_tgl_q <= 1'b0;
        end else if (ce && req_edge) begin
            rsp_q <= rd_mux;
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    a_temp_sticky: assert property (@(posedge mclk) disable iff (reset)
        ce && temp_evt.ot_fault |=> temp_q[3])
        else $error("overtemperature fault not latched");
    a_temp_zeros: assert property (@(posedge mclk) disable iff (reset)
        ce && req_edge && req_q.cmd == `PST_CMD_STAT_TEMP
        |=> rsp_q[3:0] == 4'h0 && rsp_q[15:8] == 8'h00)
        else $error("temperature status reserved bits set");
    a_cmd_unknown: assert property (@(posedge mclk) disable iff (reset)
        ce && req_edge && !known_cmd |=> cml_q[`PST_CML_CMD])
        else $error("unknown command not flagged");
    a_pec_flagged: assert property (@(posedge mclk) disable iff (reset)
        ce && ev[`PST_EV_PEC] |=> cml_q[`PST_CML_PEC] ##1
        (cml_q[`PST_CML_PEC] || $past(clr)))
        else $error("packet error flag not held");
    a_cml_zeros: assert property (@(posedge mclk) disable iff (reset)
        cml_q[3:2] == 2'h0 && cml_q[0] == 1'b0)
        else $error("unimplemented communication bits set");
    a_wdog_sticky: assert property (@(posedge mclk) disable iff (reset)
        ce && wdog_q && !clr |=> wdog_q)
        else $error("watchdog flag dropped without clear");
    a_alert_follow: assert property (@(posedge mclk) disable iff (reset)
        ce && alert_now |=> alert_request_line_n_oe)
        else $error("alert line not pulled for alerting flag");
    a_read_keeps: assert property (@(posedge mclk) disable iff (reset)
        ce && !clr |=> (cml_q & $past(cml_q)) == $past(cml_q))
        else $error("status flag lost without clear");
    a_vout_coarse: assert property (@(posedge mclk) disable iff (reset)
        ce && req_edge && req_q.cmd == `PST_CMD_READ_VOUT && !vout_fine[pg]
        |=> rsp_q == $past(vout_q[pg]))
        else $error("coarse output reading altered");
    a_mfr_global: assert property (@(posedge mclk) disable iff (reset)
        ce && req_edge && req_q.cmd == `PST_CMD_STAT_MFR
        |=> rsp_q[0] == $past(wdog_q) && rsp_q[7] == $past(disch_q[pg]))
        else $error("vendor status page mapping wrong");
    a_rd_done: assert property (@(posedge bus_clk) disable iff (lrst_q)
        lk_rd_valid |-> !lk_rd_busy ##1 !lk_rd_valid)
        else $error("read answer not a single pulse");
endmodule

// >>> testbench/power_manager_status_telemetry_bench.sv
// Self-checking bench for the status and telemetry register set.
`timescale 1ns/1ps
`include "pst_cfg.svh"
module power_manager_status_telemetry_bench;
    import pst_pkg::*;
    logic mclk, reset, ce, bus_clk;
    pst_lkev_t lk_evt;
    pst_rdreq_t lk_rd_addr;
    pst_temp_t temp_evt;
    logic lk_extra_valid, lk_rd_req, lk_rd_valid, lk_rd_busy;
    logic [7:0] lk_extra_byte, lk_pec_expected;
    logic [15:0] lk_rd_data, vin_sample, temp_sample, ev, et;
    logic nvm_fault, watchdog_timeout, vinen_faulted_off;
    logic [7:0] discharge_fault, on_attempt, shut_by_fault0, shut_by_fault1;
    logic [7:0] control_toggle, commanded_on, servo_reached, dac_driving;
    logic [7:0] dac_saturated, off_on_fault_en, adc_hires, chan_off_req;
    logic vin_valid, temp_valid, line0_n, line1_n, alert_o, alert_oe;
    logic [7:0] vout_valid;
    logic [127:0] vout_sample;
    logic [15:0] exp_q[$];
    logic [15:0] vs[8];
    logic [10:0] r;
    int bad_count, comparisons, cyc, p, q;

    pst_status u_dut (.mclk(mclk), .reset(reset), .ce(ce), .bus_clk(bus_clk),
        .lk_evt(lk_evt), .lk_extra_valid(lk_extra_valid),
        .lk_extra_byte(lk_extra_byte), .lk_pec_expected(lk_pec_expected),
        .lk_rd_req(lk_rd_req), .lk_rd_addr(lk_rd_addr),
        .lk_rd_data(lk_rd_data), .lk_rd_valid(lk_rd_valid),
        .lk_rd_busy(lk_rd_busy), .temp_evt(temp_evt), .nvm_fault(nvm_fault),
        .watchdog_timeout(watchdog_timeout),
        .vinen_faulted_off(vinen_faulted_off),
        .discharge_fault(discharge_fault), .on_attempt(on_attempt),
        .shut_by_fault0(shut_by_fault0), .shut_by_fault1(shut_by_fault1),
        .control_toggle(control_toggle), .commanded_on(commanded_on),
        .servo_reached(servo_reached), .dac_driving(dac_driving),
        .dac_saturated(dac_saturated), .off_on_fault_en(off_on_fault_en),
        .adc_hires(adc_hires), .chan_off_req(chan_off_req),
        .vin_valid(vin_valid), .vin_sample(vin_sample),
        .temp_valid(temp_valid), .temp_sample(temp_sample),
        .vout_valid(vout_valid), .vout_sample(vout_sample),
        .shared_fault_line0_n(line0_n), .shared_fault_line1_n(line1_n),
        .alert_request_line_n_o(alert_o), .alert_request_line_n_oe(alert_oe));
    pst_host_model u_host (.bus_clk(bus_clk), .lk_evt(lk_evt),
        .lk_extra_valid(lk_extra_valid), .lk_extra_byte(lk_extra_byte),
        .lk_pec_expected(lk_pec_expected), .lk_rd_req(lk_rd_req),
        .lk_rd_addr(lk_rd_addr), .lk_rd_valid(lk_rd_valid),
        .lk_rd_busy(lk_rd_busy));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // The link clock starts off phase so the two domains never line up.
    initial begin
        bus_clk = 1'b0;
        #3.7;
        forever #6 bus_clk = ~bus_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [2:0] pg,
                      input logic [15:0] e);
        exp_q.push_back(e);
        u_host.read(c, pg);
    endtask
    task automatic st();
        repeat (12) @(negedge mclk);
    endtask
    task results;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Answers are settled by the falling link edge.
    always @(negedge bus_clk) begin
        if (lk_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unasked read", 16'hDEAD, lk_rd_data);
            end else begin
                chk("read data", exp_q.pop_front(), lk_rd_data);
            end
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        ce = 1'b1;
        reset = 1'b1;
        temp_evt = '0;
        {nvm_fault, watchdog_timeout, vinen_faulted_off} = '0;
        {vin_valid, temp_valid, vout_valid, adc_hires} = '0;
        {discharge_fault, on_attempt, shut_by_fault0, shut_by_fault1} = '0;
        {control_toggle, commanded_on, servo_reached, dac_driving} = '0;
        dac_saturated = 8'h00;
        off_on_fault_en = 8'hFF;
        {line0_n, line1_n} = 2'b11;
        {vin_sample, temp_sample, vout_sample} = '0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        void'($urandom(32'h01d0_1d48));
        repeat (10) @(posedge bus_clk);
        rd(`PST_CMD_STAT_MFR, 3'h0, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            temp_evt = pst_temp_t'(4'b1000 >> i);
            @(negedge mclk);
            temp_evt = '0;
            st();
            rd(`PST_CMD_STAT_TEMP, 3'(i),
               {8'h00, 8'hF0 << (3 - i)});
        end
        rd(8'h00, 3'h0, 16'h0000);
        u_host.pulse(4'b0100);
        u_host.extra(8'h5A, 8'h5A);
        st();
        rd(`PST_CMD_STAT_CML, 3'h0, 16'h00C0);
        u_host.pulse(4'b1000);
        u_host.extra(8'h5A, 8'hA5);
        @(negedge mclk);
        nvm_fault = 1'b1;
        @(negedge mclk);
        nvm_fault = 1'b0;
        st();
        rd(`PST_CMD_STAT_CML, 3'h0, 16'h00F2);
        rd(`PST_CMD_STAT_CML, 3'h0, 16'h00F2);
        u_host.pulse(4'b0001);
        st();
        rd(`PST_CMD_STAT_CML, 3'h0, 16'h0000);
        rd(`PST_CMD_STAT_TEMP, 3'h0, 16'h0000);
        p = $urandom % 8;
        q = p ^ 1;
        @(negedge mclk);
        {discharge_fault[p], dac_saturated[p], watchdog_timeout} = 3'b111;
        {servo_reached[p], dac_driving[p], vinen_faulted_off} = 3'b111;
        @(negedge mclk);
        {discharge_fault, dac_saturated, watchdog_timeout} = '0;
        st();
        chk("off request", 16'(8'h01 << p), {8'h00, chan_off_req});
        chk("alert drive", 16'h0001, {14'h0, alert_o, alert_oe});
        rd(`PST_CMD_STAT_MFR, 3'(p), 16'h009F);
        rd(`PST_CMD_STAT_MFR, 3'(q), 16'h0003);
        @(negedge mclk);
        {line0_n, line1_n} = 2'b00;
        repeat (4) @(negedge mclk);
        {on_attempt[q], shut_by_fault0[q]} = 2'b11;
        @(negedge mclk);
        {on_attempt, shut_by_fault0} = '0;
        {line0_n, line1_n} = 2'b11;
        st();
        rd(`PST_CMD_STAT_MFR, 3'(q), 16'h0063);
        @(negedge mclk);
        control_toggle[q] = 1'b1;
        @(negedge mclk);
        control_toggle = 8'h00;
        {servo_reached, dac_driving, vinen_faulted_off} = '0;
        st();
        rd(`PST_CMD_STAT_MFR, 3'(q), 16'h0001);
        u_host.pulse(4'b0001);
        st();
        rd(`PST_CMD_STAT_MFR, 3'(p), 16'h0000);
        @(negedge mclk);
        discharge_fault[p] = 1'b1;
        @(negedge mclk);
        discharge_fault = 8'h00;
        st();
        commanded_on[p] = 1'b1;
        @(negedge mclk);
        commanded_on = 8'h00;
        // A timeout seen while the enable is low must leave no flag.
        ce = 1'b0;
        watchdog_timeout = 1'b1;
        @(negedge mclk);
        {ce, watchdog_timeout} = 2'b10;
        st();
        chk("off request", 16'h0000, {8'h00, chan_off_req});
        rd(`PST_CMD_STAT_MFR, 3'(p), 16'h0000);
        adc_hires = 8'($urandom);
        for (int c = 0; c < 8; c++) begin
            r = 11'($urandom);
            vs[c] = (adc_hires[c] && c % 2 == 1) ? {5'h1A, r} :
                16'($urandom);
            vout_sample[16*c +: 16] = (adc_hires[c] && c % 2 == 1) ?
                {{5{r[10]}}, r} : vs[c];
        end
        r = 11'($urandom);
        vin_sample = {{5{r[10]}}, r};
        ev = {5'h18, r};
        r = 11'($urandom);
        temp_sample = {{5{r[10]}}, r};
        et = {5'h1E, r};
        @(negedge mclk);
        {vin_valid, temp_valid, vout_valid} = '1;
        @(negedge mclk);
        {vin_valid, temp_valid, vout_valid} = '0;
        st();
        rd(`PST_CMD_READ_VIN, 3'h0, ev);
        rd(`PST_CMD_READ_TEMP, 3'h0, et);
        for (int c = 0; c < 8; c++) begin
            rd(`PST_CMD_READ_VOUT, 3'(c), vs[c]);
        end
        repeat (20) @(negedge bus_clk);
        chk("pending reads", 16'h0000, 16'(exp_q.size()));
        results();
    end
endmodule

// >>> testbench/pst_host_model.sv
// Host controller model that issues link reads, parser events and bytes.
`timescale 1ns/1ps
module pst_host_model (
    // Link clock
    input wire logic bus_clk,
    // Parser events and extra bytes
    output pst_pkg::pst_lkev_t lk_evt,
    output logic lk_extra_valid,
    output logic [7:0] lk_extra_byte,
    output logic [7:0] lk_pec_expected,
    // Read request and answer
    output logic lk_rd_req,
    output pst_pkg::pst_rdreq_t lk_rd_addr,
    input wire logic lk_rd_valid,
    input wire logic lk_rd_busy
);
    import pst_pkg::*;
    initial begin
        lk_evt = '0;
        lk_extra_valid = 1'b0;
        lk_extra_byte = 8'h00;
        lk_pec_expected = 8'h00;
        lk_rd_req = 1'b0;
        lk_rd_addr = '0;
    end
    // The address flips while the answer is awaited, so a block that
    // samples it late sees garbage rather than a plausible value.
    task automatic read(input logic [7:0] cmd, input logic [2:0] page);
        int n;
        n = 0;
        @(negedge bus_clk);
        while (lk_rd_busy !== 1'b0 && n < 50) begin
            @(negedge bus_clk);
            n++;
        end
        lk_rd_addr = '{cmd: cmd, page: page};
        lk_rd_req = 1'b1;
        @(negedge bus_clk);
        lk_rd_req = 1'b0;
        while (lk_rd_valid !== 1'b1 && n < 50) begin
            lk_rd_addr = ~lk_rd_addr;
            @(negedge bus_clk);
            n++;
        end
    endtask
    task automatic pulse(input logic [3:0] m);
        @(negedge bus_clk);
        lk_evt = pst_lkev_t'(m);
        @(negedge bus_clk);
        lk_evt = '0;
    endtask
    task automatic extra(input logic [7:0] b, input logic [7:0] pec);
        @(negedge bus_clk);
        lk_extra_valid = 1'b1;
        lk_extra_byte = b;
        lk_pec_expected = pec;
        @(negedge bus_clk);
        lk_extra_valid = 1'b0;
        lk_extra_byte = ~b;
        lk_pec_expected = ~pec;
    endtask
endmodule
